// ===== gptp_pkg.sv
package gptp_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [31:0] GPTP_ADDR_RELOAD = 32'hFFFF0320;
  localparam logic [31:0] GPTP_ADDR_COUNT = 32'hFFFF0324;
  localparam logic [31:0] GPTP_ADDR_CONTROL = 32'hFFFF0328;
  localparam logic [31:0] GPTP_ADDR_CLEAR = 32'hFFFF032C;
  localparam logic [31:0] GPTP_ADDR_CAPTURE = 32'hFFFF0330;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] GPTP_RELOAD_RESET = 32'h00000000;
  localparam logic [31:0] GPTP_COUNT_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] GPTP_CONTROL_RESET = 32'h01000000;
  localparam logic [31:0] GPTP_CAPTURE_RESET = 32'h00000000;

  // ****************************************************************
  // control field codes
  // ****************************************************************
  localparam logic [2:0] GPTP_CLK_CORE = 3'h0;
  localparam logic [2:0] GPTP_CLK_LPOSC = 3'h1;
  localparam logic [2:0] GPTP_CLK_PIN_A = 3'h2;
  localparam logic [2:0] GPTP_CLK_PIN_B = 3'h3;
  localparam logic [1:0] GPTP_FMT_BINARY = 2'h0;
  localparam logic [1:0] GPTP_FMT_TOD23 = 2'h2;
  localparam logic [1:0] GPTP_FMT_TOD255 = 2'h3;
  localparam logic [3:0] GPTP_PRE_DIV1 = 4'h0;
  localparam logic [3:0] GPTP_PRE_DIV16 = 4'h4;
  localparam logic [3:0] GPTP_PRE_DIV256 = 4'h8;
  localparam logic [3:0] GPTP_PRE_DIV32768 = 4'hF;
  localparam logic [14:0] GPTP_PRE_LAST16 = 15'h000F;
  localparam logic [14:0] GPTP_PRE_LAST256 = 15'h00FF;
  localparam logic [14:0] GPTP_PRE_LAST32768 = 15'h7FFF;

  // ****************************************************************
  // time-of-day field limits
  // ****************************************************************
  localparam logic [7:0] GPTP_HUND_MAX = 8'h63;
  localparam logic [7:0] GPTP_SEXA_MAX = 8'h3B;
  localparam logic [7:0] GPTP_HOUR23_MAX = 8'h17;
  localparam logic [7:0] GPTP_HOUR255_MAX = 8'hFF;

  localparam int GPTP_EVENT_COUNT = 18;

  typedef struct packed {
    logic [7:0] ps_target;
    logic ps_en;
    logic [2:0] rsv;
    logic cmp_flag;
    logic irq_sel;
    logic cap_en;
    logic [4:0] evt_sel;
    logic [2:0] clk_sel;
    logic count_up;
    logic enable;
    logic periodic;
    logic [1:0] fmt;
    logic [3:0] prescale;
  } gptp_ctl_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gptp_apb_rsp_t;

endpackage

// ===== gptp_timer.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// - postscaler counts timeouts, enable bit 23, target 31:24
// - zero target means one; read returns counter
// - bit 18 picks postscaler or timeout interrupt
// - read-only bit 19 set on postscaler match
// - pin or oscillator clocking survives low power
// - in periodic mode, overflow reloads counter from reload register
// - any write to clear strobe clears interrupt, unless a new event lands in the same cycle
// - live count readable, resets to all ones
// - capture register holds count at event
// - bit 17 enables capture, 16:12 pick event
// - bits 11:9 select counter clock source
// - bit 8 chooses up or down counting
// - bit 7 enables counter, off after reset
// - bit 6 periodic, clear means free running
// - bits 5:4 select binary or time format
// - bits 3:0 select prescale 1/16/256/32768
// - capture on event rise, counter keeps running
// - control crosses two stages of timer ticks
module gptp_timer
  import gptp_pkg::*;
#(
  parameter int EVENT_COUNT = GPTP_EVENT_COUNT
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LPOSC_CLK,
  input wire logic EXT_CLK_A,
  input wire logic EXT_CLK_B,
  input wire logic LOW_POWER,
  input wire logic [EVENT_COUNT-1:0] EVENTS,
  output logic TIMER_IRQ
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [14:0] presc_last(input logic [3:0] code);
    logic [14:0] r;
    r = 15'h0000;
    case (code)
      GPTP_PRE_DIV16: r = GPTP_PRE_LAST16;
      GPTP_PRE_DIV256: r = GPTP_PRE_LAST256;
      GPTP_PRE_DIV32768: r = GPTP_PRE_LAST32768;
      default: r = 15'h0000;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] hour_max(input logic [1:0] fmt);
    return (fmt == GPTP_FMT_TOD255) ? GPTP_HOUR255_MAX : GPTP_HOUR23_MAX;
  endfunction

  function automatic logic [31:0] tod_top(input logic [1:0] fmt);
    return {hour_max(fmt), GPTP_SEXA_MAX, GPTP_SEXA_MAX, GPTP_HUND_MAX};
  endfunction

  // one time field between zero and its top; bit 8 is the carry or borrow
  function automatic logic [8:0] fld_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic up);
    logic [8:0] r;
    r = 9'h000;
    if (up) begin
      r = (v == top) ? 9'h100 : {1'b0, 8'(v + 8'h01)};
    end else begin
      r = (v == 8'h00) ? {1'b1, top} : {1'b0, 8'(v - 8'h01)};
    end
    return r;
  endfunction

  // step one time-of-day value, carries and borrows ripple upward
  function automatic logic [31:0] tod_step(input logic [31:0] v, input logic up,
                                           input logic [1:0] fmt);
    logic [8:0] hu;
    logic [8:0] se;
    logic [8:0] mi;
    logic [8:0] ho;
    hu = fld_step(v[7:0], GPTP_HUND_MAX, up);
    se = {1'b0, v[15:8]};
    mi = {1'b0, v[23:16]};
    ho = {1'b0, v[31:24]};
    if (hu[8]) begin
      se = fld_step(v[15:8], GPTP_SEXA_MAX, up);
    end
    if (se[8]) begin
      mi = fld_step(v[23:16], GPTP_SEXA_MAX, up);
    end
    if (mi[8]) begin
      ho = fld_step(v[31:24], hour_max(fmt), up);
    end
    return {ho[7:0], mi[7:0], se[7:0], hu[7:0]};
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_sync_r;
  wire logic rstn_i = rst_sync_r;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  gptp_ctl_t ctl_r;
  logic [31:0] reload_r;
  logic [31:0] count_r;
  logic [31:0] capture_r;
  logic [7:0] ps_cnt_r;
  logic cmp_flag_r;
  logic irq_r;
  gptp_apb_rsp_t rsp_r;
  gptp_apb_rsp_t rsp_nxt;

  wire logic hit_reload = (PADDR == GPTP_ADDR_RELOAD);
  wire logic hit_count = (PADDR == GPTP_ADDR_COUNT);
  wire logic hit_control = (PADDR == GPTP_ADDR_CONTROL);
  wire logic hit_clear = (PADDR == GPTP_ADDR_CLEAR);
  wire logic hit_capture = (PADDR == GPTP_ADDR_CAPTURE);
  wire logic hit_any = hit_reload | hit_count | hit_control | hit_clear | hit_capture;
  // answer in the first cycle of the access phase, with no wait state
  wire logic setup_ph = PSEL & ~PENABLE & ~rsp_r.pready;
  wire logic wr_take = PSEL & PENABLE & rsp_r.pready & PWRITE & ~rsp_r.pslverr;

  gptp_ctl_t ctl_view;
  always_comb begin
    ctl_view = ctl_r;
    ctl_view.ps_target = ps_cnt_r;
    ctl_view.cmp_flag = cmp_flag_r;
    ctl_view.rsv = 3'h0;
  end

  // clear strobe is write-only and reads as zero
  wire logic [31:0] rd_mux = hit_reload ? reload_r :
                             hit_count ? count_r :
                             hit_control ? ctl_view :
                             hit_capture ? capture_r : 32'h00000000;

  always_comb begin
    rsp_nxt.pready = setup_ph;
    rsp_nxt.pslverr = setup_ph & ~hit_any;
    rsp_nxt.prdata = (setup_ph & ~PWRITE) ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_r <= '0;
    end else if (CE) begin
      rsp_r <= rsp_nxt;
    end
  end

  assign PRDATA = rsp_r.prdata;
  assign PREADY = rsp_r.pready;
  assign PSLVERR = rsp_r.pslverr;

  wire logic wr_control = wr_take & hit_control;
  wire logic wr_clear = wr_take & hit_clear;

  // ****************************************************************
  // software registers
  // ****************************************************************
  gptp_ctl_t ctl_nxt;
  always_comb begin
    ctl_nxt = gptp_ctl_t'(PWDATA);
    // zero target behaves as a count of one
    if (ctl_nxt.ps_target == 8'h00) begin
      ctl_nxt.ps_target = 8'h01;
    end
    ctl_nxt.cmp_flag = 1'b0;
    ctl_nxt.rsv = 3'h0;
  end

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_r <= gptp_ctl_t'(GPTP_CONTROL_RESET);
      reload_r <= GPTP_RELOAD_RESET;
    end else if (CE) begin
      if (wr_control) begin
        ctl_r <= ctl_nxt;
      end
      if (wr_take & hit_reload) begin
        reload_r <= PWDATA;
      end
    end
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  // the pins are sampled on CLOCK, so an external clock must stay well
  // below half the core rate to be seen edge by edge
  logic lposc_q_r;
  logic pina_q_r;
  logic pinb_q_r;
  logic src_tick;

  always_comb begin
    case (ctl_r.clk_sel)
      GPTP_CLK_CORE: src_tick = 1'b1;
      GPTP_CLK_LPOSC: src_tick = LPOSC_CLK & ~lposc_q_r;
      GPTP_CLK_PIN_A: src_tick = EXT_CLK_A & ~pina_q_r;
      GPTP_CLK_PIN_B: src_tick = EXT_CLK_B & ~pinb_q_r;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      lposc_q_r <= 1'b0;
      pina_q_r <= 1'b0;
      pinb_q_r <= 1'b0;
    end else if (CE) begin
      lposc_q_r <= LPOSC_CLK;
      pina_q_r <= EXT_CLK_A;
      pinb_q_r <= EXT_CLK_B;
    end
  end

  // ****************************************************************
  // control transfer into the timer logic
  // ****************************************************************
  // both stages step on the selected timer clock, so a new setting
  // reaches the counter only after two of its edges
  gptp_ctl_t ctl_s1_r;
  gptp_ctl_t ctl_s2_r;
  logic [31:0] reload_s1_r;
  logic [31:0] reload_s2_r;

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_s1_r <= gptp_ctl_t'(GPTP_CONTROL_RESET);
      ctl_s2_r <= gptp_ctl_t'(GPTP_CONTROL_RESET);
      reload_s1_r <= GPTP_RELOAD_RESET;
      reload_s2_r <= GPTP_RELOAD_RESET;
    end else if (CE && src_tick) begin
      ctl_s1_r <= ctl_r;
      ctl_s2_r <= ctl_s1_r;
      reload_s1_r <= reload_r;
      reload_s2_r <= reload_s1_r;
    end
  end

  // ****************************************************************
  // prescaler and counter
  // ****************************************************************
  logic [14:0] presc_r;
  logic en_q_r;

  // the core clock stops in low power; pin and oscillator sources do not
  wire logic core_halt = LOW_POWER & (ctl_s2_r.clk_sel == GPTP_CLK_CORE);
  wire logic run = ctl_s2_r.enable & ~core_halt;
  wire logic presc_done = (presc_r == presc_last(ctl_s2_r.prescale));
  wire logic cnt_tick = src_tick & run & presc_done;
  wire logic is_tod = ctl_s2_r.fmt[1];
  wire logic [31:0] top_val = is_tod ? tod_top(ctl_s2_r.fmt) : GPTP_COUNT_RESET;
  wire logic at_end = ctl_s2_r.count_up ? (count_r == top_val) : (count_r == 32'h00000000);
  wire logic timeout = cnt_tick & at_end;
  wire logic [31:0] wrap_val = ctl_s2_r.count_up ? 32'h00000000 : top_val;
  wire logic [31:0] step_val = is_tod ? tod_step(count_r, ctl_s2_r.count_up, ctl_s2_r.fmt) :
                               ctl_s2_r.count_up ? 32'(count_r + 32'h00000001) :
                               32'(count_r - 32'h00000001);
  wire logic [31:0] end_val = ctl_s2_r.periodic ? reload_s2_r : wrap_val;
  wire logic [31:0] count_nxt = at_end ? end_val : step_val;

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_r <= 15'h0000;
      en_q_r <= 1'b0;
      count_r <= GPTP_COUNT_RESET;
    end else if (CE && src_tick) begin
      en_q_r <= run;
      if (!run) begin
        presc_r <= 15'h0000;
      end else if (presc_done) begin
        presc_r <= 15'h0000;
      end else begin
        presc_r <= 15'(presc_r + 15'h0001);
      end
      // a fresh start loads the reload value before counting
      if (run && !en_q_r) begin
        count_r <= reload_s2_r;
      end else if (cnt_tick) begin
        count_r <= count_nxt;
      end
    end
  end

  // ****************************************************************
  // postscaler
  // ****************************************************************
  wire logic [7:0] ps_inc = 8'(ps_cnt_r + 8'h01);
  wire logic ps_match = timeout & ctl_s2_r.ps_en & (ps_inc == ctl_s2_r.ps_target);

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      ps_cnt_r <= 8'h00;
    end else if (CE) begin
      if (!ctl_s2_r.ps_en) begin
        ps_cnt_r <= 8'h00;
      end else if (ps_match) begin
        ps_cnt_r <= 8'h00;
      end else if (timeout) begin
        ps_cnt_r <= ps_inc;
      end
    end
  end

  // ****************************************************************
  // interrupt and compare flag
  // ****************************************************************
  // a new event in the clearing cycle keeps its flag set
  wire logic irq_evt = ctl_s2_r.irq_sel ? ps_match : timeout;

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else if (CE) begin
      if (irq_evt) begin
        irq_r <= 1'b1;
      end else if (wr_clear) begin
        irq_r <= 1'b0;
      end
      if (ps_match) begin
        cmp_flag_r <= 1'b1;
      end else if (wr_clear) begin
        cmp_flag_r <= 1'b0;
      end
    end
  end

  assign TIMER_IRQ = irq_r;

  // ****************************************************************
  // event capture
  // ****************************************************************
  // only the first edge of the event is seen; a held level does not
  // recapture, and the counter is never disturbed
  logic [EVENT_COUNT-1:0] evt_q_r;
  wire logic [EVENT_COUNT-1:0] evt_rise = EVENTS & ~evt_q_r;
  wire logic evt_valid = (32'(ctl_r.evt_sel) < EVENT_COUNT);
  wire logic cap_hit = ctl_r.cap_en & evt_valid & evt_rise[ctl_r.evt_sel];

  always_ff @(posedge CLOCK or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_q_r <= '0;
      capture_r <= GPTP_CAPTURE_RESET;
    end else if (CE) begin
      evt_q_r <= EVENTS;
      if (cap_hit) begin
        capture_r <= count_r;
      end
    end
  end

endmodule

// ===== gptp_timer_props.sv
`timescale 1ns/1ns
module gptp_timer_props
  import gptp_pkg::*;
#(
  parameter int EVENT_COUNT = GPTP_EVENT_COUNT
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic LPOSC_CLK,
  input wire logic EXT_CLK_A,
  input wire logic EXT_CLK_B,
  input wire logic LOW_POWER,
  input wire logic [EVENT_COUNT-1:0] EVENTS,
  input wire logic TIMER_IRQ
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  wire acc_done = PSEL && PENABLE && PREADY;
  wire clr_wr = acc_done && PWRITE && (PADDR == GPTP_ADDR_CLEAR);
  wire hit_map = (PADDR == GPTP_ADDR_RELOAD) || (PADDR == GPTP_ADDR_COUNT) ||
    (PADDR == GPTP_ADDR_CONTROL) || (PADDR == GPTP_ADDR_CLEAR) ||
    (PADDR == GPTP_ADDR_CAPTURE);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  // ****************************************************************
  // assertions
  // ****************************************************************
  ready_pulse_a: assert property (acc_done && CE |=> !PREADY)
    else $error("ready held past one cycle");
  setup_answer_a: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("no answer after setup");
  setup_quiet_a: assert property (PSEL && !PENABLE |-> !PREADY)
    else $error("answer during setup");
  rdata_idle_a: assert property (!PREADY || PWRITE |-> PRDATA == 32'h00000000)
    else $error("read data outside read answer");
  err_map_a: assert property (PREADY && PSEL |-> PSLVERR == !hit_map)
    else $error("error flag wrong for address");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  irq_hold_a: assert property (TIMER_IRQ && !clr_wr |=> TIMER_IRQ)
    else $error("interrupt dropped without clear");
  irq_clear_a: assert property (clr_wr && CE |=> !TIMER_IRQ)
    else $error("interrupt survived clear write");
  ce_freeze_a: assert property (!CE |=> $stable(PREADY) && $stable(TIMER_IRQ) && $stable(PRDATA))
    else $error("state moved with clock enable low");

  read_seen_c: cover property (acc_done && !PWRITE);
  irq_rise_c: cover property ($rose(TIMER_IRQ));
  err_seen_c: cover property (PSLVERR);
  clear_pend_c: cover property (clr_wr && TIMER_IRQ);
endmodule

bind gptp_timer gptp_timer_props #(.EVENT_COUNT(EVENT_COUNT)) props_u (
  .CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LPOSC_CLK(LPOSC_CLK), .EXT_CLK_A(EXT_CLK_A), .EXT_CLK_B(EXT_CLK_B),
  .LOW_POWER(LOW_POWER), .EVENTS(EVENTS), .TIMER_IRQ(TIMER_IRQ)
);

// ===== gptp_timer_test.sv
`timescale 1ns/1ns
module gptp_timer_test
  import gptp_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic lposc_clk = 1'b0;
  logic ext_clk_a = 1'b0;
  logic ext_clk_b = 1'b0;
  logic low_power = 1'b0;
  logic [17:0] events = 18'h00000;
  logic [4:0] div_r = 5'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_irq;
  logic [31:0] q, c1, c2;
  logic e;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2 clock = ~clock;

  // slow sources stay well under half the core rate
  always @(posedge clock) begin
    div_r <= div_r + 5'h01;
    lposc_clk <= div_r[3];
    ext_clk_a <= div_r[2];
    ext_clk_b <= div_r[4];
  end

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      close_out();
    end
  end

  gptp_timer dut_u (
    .CLOCK(clock), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LPOSC_CLK(lposc_clk), .EXT_CLK_A(ext_clk_a), .EXT_CLK_B(ext_clk_b),
    .LOW_POWER(low_power), .EVENTS(events), .TIMER_IRQ(timer_irq)
  );

  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ready, data and error are read as they stood at the edge, before its updates land;
  // only the run's own timeout ends a wait for ready
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic pulse(input int i);
    @(posedge clock);
    events <= 18'h00001 << i;
    @(posedge clock);
    events <= 18'h00000;
  endtask

  // enable, wait for the interrupt, check flags, stop, then check count
  task automatic run_case(input logic [31:0] ld, input logic [31:0] ctl, input logic [31:0] msk,
                          input logic [31:0] ex, input int lo, input int hi);
    int n;
    n = 0;
    wr(GPTP_ADDR_RELOAD, ld);
    wr(GPTP_ADDR_CONTROL, ctl);
    while (timer_irq !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n = n + 1;
    end
    chk("irq_delay", 32'(n >= lo && n <= hi), 32'h00000001);
    apb(1'b0, GPTP_ADDR_CONTROL, 32'h00000000, q, e);
    chk("ctl_flags", q & 32'hFF8C0000, (ctl & 32'h00840000) | {12'h000, ctl[23], 19'h00000});
    wr(GPTP_ADDR_CONTROL, 32'h00000000);
    repeat (80) @(posedge clock);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, q, e);
    chk("count_end", q & msk, ex);
    wr(GPTP_ADDR_CLEAR, 32'h000000A5);
    @(negedge clock);
    chk("irq_clr", 32'(timer_irq), 32'h00000000);
    $display("test case %h done", ctl);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, GPTP_ADDR_RELOAD, 32'h00000000, q, e);
    chk("reload_rst", q, GPTP_RELOAD_RESET);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, q, e);
    chk("count_rst", q, GPTP_COUNT_RESET);
    apb(1'b0, GPTP_ADDR_CONTROL, 32'h00000000, q, e);
    chk("ctl_rst", q, 32'h00000000);
    apb(1'b0, GPTP_ADDR_CAPTURE, 32'h00000000, q, e);
    chk("cap_rst", q, GPTP_CAPTURE_RESET);
    apb(1'b0, GPTP_ADDR_CLEAR, 32'h00000000, q, e);
    chk("clr_read", q, 32'h00000000);
    apb(1'b0, 32'hFFFF0334, 32'h00000000, q, e);
    chk("unmapped", 32'(e), 32'h00000001);
    wr(GPTP_ADDR_RELOAD, 32'hA5A55A5A);
    apb(1'b0, GPTP_ADDR_RELOAD, 32'h00000000, q, e);
    chk("reload_rw", q, 32'hA5A55A5A);
    wr(GPTP_ADDR_COUNT, 32'h12345678);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, q, e);
    chk("count_ro", q, GPTP_COUNT_RESET);
    wr(GPTP_ADDR_CONTROL, 32'h00080000);
    apb(1'b0, GPTP_ADDR_CONTROL, 32'h00000000, q, e);
    chk("ctl_ro_bits", q, 32'h00000000);
    $display("test registers done");

    run_case(32'h00000004, 32'h000000C0, 32'hFFFFFFF8, 32'h0, 6, 13);
    run_case(32'h00000002, 32'h00000080, 32'hFFFFFF00, 32'hFFFFFF00, 4, 11);
    run_case(32'hFFFFFFFD, 32'h000001C0, 32'hFFFFFFFC, 32'hFFFFFFFC, 4, 11);
    run_case(32'hFFFFFFFD, 32'h00000180, 32'hFFFFFF00, 32'h0, 4, 11);
    run_case(32'h00000004, 32'h038400C0, 32'hFFFFFFF8, 32'h0, 16, 23);
    run_case(32'h00000004, 32'h008400C0, 32'hFFFFFFF8, 32'h0, 6, 13);
    run_case(32'h00000004, 32'h000000C4, 32'hFFFFFFF8, 32'h0, 60, 110);
    run_case(32'h00000004, 32'h000000C8, 32'hFFFFFFF8, 32'h0, 1200, 1350);
    run_case(32'h173B3B62, 32'h000001A0, 32'hFFFFFF00, 32'h0, 3, 10);
    run_case(32'hFF3B3B62, 32'h000001B0, 32'hFFFFFF00, 32'h0, 3, 10);
    run_case(32'h173B3A62, 32'h000001A0, 32'hFFFFFF00, 32'h0, 100, 112);
    run_case(32'hFFFFFFFD, 32'h00000190, 32'hFFFFFF00, 32'h0, 4, 11);
    run_case(32'h00000004, 32'h000002C0, 32'hFFFFFFF8, 32'h0, 100, 220);
    run_case(32'h00000004, 32'h000004C0, 32'hFFFFFFF8, 32'h0, 50, 120);
    run_case(32'h00000004, 32'h000006C0, 32'hFFFFFFF8, 32'h0, 220, 400);

    wr(GPTP_ADDR_RELOAD, 32'h00001000);
    wr(GPTP_ADDR_CONTROL, 32'h00025080);
    repeat (10) @(posedge clock);
    pulse(4);
    apb(1'b0, GPTP_ADDR_CAPTURE, 32'h00000000, q, e);
    chk("cap_other_evt", q, 32'h00000000);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c1, e);
    pulse(5);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c2, e);
    apb(1'b0, GPTP_ADDR_CAPTURE, 32'h00000000, q, e);
    chk("cap_window", 32'(q <= c1 && q >= c2 && q != 0), 32'h00000001);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c1, e);
    chk("runs_on", 32'(c1 < c2), 32'h00000001);
    $display("test capture done");

    @(posedge clock);
    low_power <= 1'b1;
    wr(GPTP_ADDR_CONTROL, 32'h00000080);
    repeat (10) @(posedge clock);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c1, e);
    @(posedge clock);
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    ce <= 1'b1;
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c2, e);
    chk("lp_core_halt", c2, c1);
    wr(GPTP_ADDR_CONTROL, 32'h00000280);
    repeat (40) @(posedge clock);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c1, e);
    repeat (40) @(posedge clock);
    apb(1'b0, GPTP_ADDR_COUNT, 32'h00000000, c2, e);
    chk("lp_osc_runs", 32'(c1 != c2), 32'h00000001);
    @(posedge clock);
    low_power <= 1'b0;
    wr(GPTP_ADDR_CONTROL, 32'h00000000);
    repeat (80) @(posedge clock);
    wr(GPTP_ADDR_CLEAR, 32'h00000000);
    $display("test low power done");
    close_out();
  end
endmodule
